// >>> rtl/cpm_map.vh
// Purpose: Register indices, field positions, codes and reset values of the motion block.
// Assumes: Included by cpm_top.v and by the simulation checker and bench.
// Notes: Word registers sit at register indices on the plain register port.
`ifndef CPM_MAP_VH
`define CPM_MAP_VH
`define CPM_A_FACTOR 4'h0
`define CPM_A_SPEED 4'h1
`define CPM_A_DIST 4'h2
`define CPM_A_START 4'h3
`define CPM_A_PAUSE 4'h4
`define CPM_A_DEV 4'h5
`define CPM_A_RESULT 4'h6
`define CPM_A_SELECT 4'h7
`define CPM_A_REF_LO 4'h8
`define CPM_A_REF_HI 4'h9
`define CPM_A_MPOS_LO 4'ha
`define CPM_A_MPOS_HI 4'hb
`define CPM_A_INC_LO 4'hc
`define CPM_A_INC_HI 4'hd
`define CPM_A_CMD 4'he
`define CPM_A_MODE 4'hf
`define CPM_B_PROF 0
`define CPM_B_JOGF 1
`define CPM_B_JOGR 2
`define CPM_B_WIRE 3
`define CPM_B_DIR 4
`define CPM_B_SERR 5
`define CPM_B_FFWD 6
`define CPM_B_BUSY 7
`define CPM_B_PSTART 8
`define CPM_B_PULSE 9
`define CPM_B_RST1 10
`define CPM_B_RST2 11
`define CPM_B_RST3 12
`define CPM_B_REFSW 13
`define CPM_MODE_COMM 16'h0008
`define CPM_MODE_POS 16'h0009
`define CPM_MODE_RST 16'h0000
`define CPM_RST_MANUAL 16'h0064
`define CPM_RST_PSPEED 16'h03e8
`define CPM_RST_DIST 16'h001e
`define CPM_RST_START 16'h0001
`define CPM_RST_PAUSE 16'h0001
`define CPM_RST_WINDOW 16'h0064
`define CPM_RST_GAIN 16'h0064
`define CPM_RST_ACCEL 16'h0002
`define CPM_GAIN_MAX 16'h7d00
`define CPM_ACC_MIN 16'h0002
`define CPM_ACC_MAX 16'h7530
`define CPM_ERR_NONE 16'h0000
`define CPM_ERR_NOTRUN 16'h0001
`define CPM_ERR_PHASE 16'h0002
`define CPM_ERR_POLES 16'h0003
`define CPM_ERR_RESOLVER 16'h0004
`define CPM_ERR_DELAY 16'h0005
`define CPM_ERR_ABORT 16'h0063
`define CPM_STEPS_REV 32'h0000_1000
`define CPM_SP_FULL_POS 16'h0001
`define CPM_SP_HALF_POS 16'h0002
`define CPM_SP_FULL_NEG 16'h0003
`define CPM_TENTH_NS 100000000
`define CPM_MS_NS 1000000
`define CPM_CLK_NS 4
`endif

// >>> rtl/cpm_top.v
// Purpose: Commissioning and positioner motion logic of a servo drive.
// Assumes: One 250 MHz clock; register port answers reads one cycle later.
// Notes: Speed outputs are signed rpm references for the speed loop.
// ----------------------------------------
// How it works
// ----------------------------------------
// How it works
// - Jog bits turn shaft at manual speed.
// - Wiring test runs, bit clears when done.
// - Wiring test results use fixed error codes.
// - Query selector picks diagnostic result word.
// - Starting point chooses first profile move.
// - Zero speed pause between profile moves.
// - Trapezoid at profile speed over distance.
// - Vibration test accumulates shaft vibration magnitude.
// - Positioner start moves by step count.
// - Direction bit picks sign, count positive.
// - Busy flag set; profile parameters locked.
// - Acceleration time sets positioning ramp.
// - Pulse input times factor adds to count.
// - Increment clear zeroes step count.
// - Servo error flag sticks above window.
// - Three position resets, only when idle.
// - Feed forward added only when enabled.
// - Proportional gain from gain parameter.
// - Mode select picks commissioning or positioning.
// - Mode drives reference only when switched.
`include "cpm_map.vh"
`timescale 1ns/1ps
`default_nettype none
module cpm_top #(
	parameter integer RAMP_DIV = 250,
	parameter integer WIRE_CYCLES = 1000
) (
	// Clock and reset
	input wire i_sys_clk,
	input wire i_rst_n,
	// Register port
	input wire [3:0] i_addr,
	input wire [15:0] i_wdata,
	input wire i_wr,
	input wire i_rd,
	output reg [15:0] o_rdata,
	// Motor side
	input wire [31:0] i_abs_shaft,
	input wire signed [31:0] i_motor_delta,
	input wire [15:0] i_vibration,
	input wire i_pulse,
	input wire [2:0] i_wire_fault,
	input wire i_hw_enable,
	input wire i_sw_enable,
	input wire [15:0] i_disable_delay,
	// Speed loop side
	output reg signed [15:0] o_speed_ref,
	output reg o_ref_valid,
	output reg signed [31:0] o_pos_ctrl
);
	localparam [2:0] S_IDLE = 3'd0;
	localparam [2:0] S_RUN = 3'd1;
	localparam [2:0] S_PAUSE = 3'd2;
	localparam [2:0] S_WIRE = 3'd3;
	localparam [2:0] S_POS = 3'd4;
	localparam integer TENTH_CYC = `CPM_TENTH_NS / `CPM_CLK_NS;
	localparam integer MS_CYC = `CPM_MS_NS / `CPM_CLK_NS;

	reg [15:0] factor_r, speed_r, dist_r, start_r, pause_r, dev_r, window_r, select_r;
	reg [15:0] result_r, werr_r;
	reg [31:0] ref_r, mpos_r, inc_r, vib_r, remain_r;
	reg [15:0] mode_r;
	reg [15:0] cmd_r, cmd_prev_r;
	reg [2:0] state_r;
	reg signed [15:0] prof_spd_r;
	reg dir_r, ph_r;
	reg [31:0] tick_r, pause_cnt_r;
	reg pulse_prev_r;
	reg [15:0] accel_r;

	wire is_comm = (mode_r == `CPM_MODE_COMM);
	wire is_pos = (mode_r == `CPM_MODE_POS);
	wire busy = (state_r == S_POS);
	wire [15:0] rise = cmd_r & ~cmd_prev_r;
	wire wr_cmd = i_wr && (i_addr == `CPM_A_CMD);
	wire pulse_edge = i_pulse && !pulse_prev_r;
	wire signed [31:0] pos_err = $signed(ref_r) - $signed(mpos_r);
	wire [31:0] abs_err = pos_err[31] ? (~pos_err + 32'h0000_0001) : pos_err;
	wire signed [31:0] gain_term = $signed({16'h0000, select_r}) * pos_err;
	wire [31:0] dist_steps = {16'h0000, dist_r} * `CPM_STEPS_REV;
	wire [47:0] pulse_prod = {16'h0000, inc_r} + {32'h0000_0000, factor_r};
	wire [15:0] accel_eff = (accel_r < `CPM_ACC_MIN) ? `CPM_ACC_MIN : accel_r;

	always @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			factor_r <= `CPM_RST_MANUAL;
			speed_r <= `CPM_RST_PSPEED;
			dist_r <= `CPM_RST_DIST;
			start_r <= `CPM_RST_START;
			pause_r <= `CPM_RST_PAUSE;
			dev_r <= 16'h0000;
			window_r <= `CPM_RST_WINDOW;
			select_r <= 16'h0000;
			werr_r <= `CPM_ERR_NOTRUN;
			ref_r <= 32'h0000_0000;
			mpos_r <= 32'h0000_0000;
			inc_r <= 32'h0000_0000;
			vib_r <= 32'h0000_0000;
			remain_r <= 32'h0000_0000;
			mode_r <= `CPM_MODE_RST;
			cmd_r <= 16'h0000;
			cmd_prev_r <= 16'h0000;
			state_r <= S_IDLE;
			prof_spd_r <= 16'sh0000;
			dir_r <= 1'b0;
			ph_r <= 1'b0;
			tick_r <= 32'h0000_0000;
			pause_cnt_r <= 32'h0000_0000;
			pulse_prev_r <= 1'b0;
			accel_r <= `CPM_RST_ACCEL;
		end else begin
			cmd_prev_r <= cmd_r;
			pulse_prev_r <= i_pulse;
			mpos_r <= mpos_r + i_motor_delta;
			// ----------------------------------------
			// Register writes
			// ----------------------------------------
			// Profile words are frozen while a positioning move runs.
			if (i_wr && !busy) begin
				case (i_addr)
				`CPM_A_FACTOR: factor_r <= i_wdata;
				`CPM_A_SPEED: begin
					speed_r <= i_wdata;
					accel_r <= (i_wdata > `CPM_ACC_MAX) ? `CPM_ACC_MAX : i_wdata;
				end
				`CPM_A_DIST: dist_r <= i_wdata;
				`CPM_A_START: start_r <= i_wdata;
				`CPM_A_PAUSE: pause_r <= i_wdata;
				`CPM_A_RESULT: window_r <= i_wdata;
				`CPM_A_SELECT: select_r <= (is_pos && i_wdata > `CPM_GAIN_MAX) ?
					`CPM_GAIN_MAX : i_wdata;
				`CPM_A_REF_LO: ref_r[15:0] <= i_wdata;
				`CPM_A_REF_HI: ref_r[31:16] <= i_wdata;
				`CPM_A_MODE: mode_r <= i_wdata;
				default: ;
				endcase
			end
			if (wr_cmd) begin
				cmd_r <= i_wdata;
				cmd_r[`CPM_B_BUSY] <= busy;
				// Servo error sticks; software may only clear it, set wins.
				cmd_r[`CPM_B_SERR] <= cmd_r[`CPM_B_SERR] & i_wdata[`CPM_B_SERR];
			end
			if (is_pos && abs_err > {16'h0000, window_r})
				cmd_r[`CPM_B_SERR] <= 1'b1;
			// ----------------------------------------
			// Step count: writes, pulses, clear
			// ----------------------------------------
			if (i_wr && i_addr == `CPM_A_INC_LO)
				inc_r[15:0] <= i_wdata;
			else if (i_wr && i_addr == `CPM_A_INC_HI)
				inc_r[31:16] <= i_wdata;
			else if (is_pos && rise[`CPM_B_JOGR])
				inc_r <= 32'h0000_0000;
			else if (is_pos && cmd_r[`CPM_B_PULSE] && pulse_edge)
				inc_r <= pulse_prod[31:0];
			// ----------------------------------------
			// Vibration accumulator
			// ----------------------------------------
			if (i_wr && i_addr == `CPM_A_INC_LO && is_comm)
				vib_r <= {16'h0000, i_wdata};
			else if (is_comm && state_r == S_IDLE && cmd_r[`CPM_B_DIR] &&
				!cmd_r[`CPM_B_JOGF] && !cmd_r[`CPM_B_JOGR] && !cmd_r[`CPM_B_PROF])
				vib_r <= vib_r + {16'h0000, i_vibration};
			// ----------------------------------------
			// Position resets, idle only
			// ----------------------------------------
			if (is_pos && !busy) begin
				if (rise[`CPM_B_RST1]) begin
					mpos_r <= 32'h0000_0000;
					ref_r <= 32'h0000_0000;
				end else if (rise[`CPM_B_RST2]) begin
					mpos_r <= i_abs_shaft;
					ref_r <= i_abs_shaft;
				end else if (rise[`CPM_B_RST3]) begin
					ref_r <= mpos_r;
				end
			end
			// ----------------------------------------
			// Sequencer
			// ----------------------------------------
			case (state_r)
			S_IDLE: begin
				prof_spd_r <= 16'sh0000;
				tick_r <= 32'h0000_0000;
				if (is_comm && rise[`CPM_B_WIRE]) begin
					state_r <= S_WIRE;
				end else if (is_comm && rise[`CPM_B_PROF]) begin
					state_r <= S_RUN;
					ph_r <= 1'b0;
					dir_r <= (start_r == `CPM_SP_FULL_NEG);
					remain_r <= (start_r == `CPM_SP_HALF_POS) ? {1'b0, dist_steps[31:1]} :
						dist_steps;
				end else if (is_pos && rise[`CPM_B_PSTART]) begin
					state_r <= S_POS;
					remain_r <= inc_r;
					dir_r <= cmd_r[`CPM_B_DIR];
				end
			end
			S_WIRE: begin
				tick_r <= tick_r + 32'h0000_0001;
				if (!is_comm) begin
					werr_r <= `CPM_ERR_ABORT;
					cmd_r[`CPM_B_WIRE] <= 1'b0;
					state_r <= S_IDLE;
				end else if (tick_r == WIRE_CYCLES) begin
					if (i_disable_delay != 16'h0000)
						werr_r <= `CPM_ERR_DELAY;
					else if (i_sw_enable || !i_hw_enable)
						werr_r <= `CPM_ERR_NOTRUN;
					else
						werr_r <= {13'h0000, i_wire_fault};
					cmd_r[`CPM_B_WIRE] <= 1'b0;
					state_r <= S_IDLE;
				end
			end
			S_RUN, S_POS: begin
				// Trapezoid: ramp one rpm per divided tick, brake when near the end.
				tick_r <= tick_r + 32'h0000_0001;
				if (!(is_comm || is_pos) || (state_r == S_RUN && !cmd_r[`CPM_B_PROF])) begin
					state_r <= S_IDLE;
				end else if (remain_r == 32'h0000_0000) begin
					if (state_r == S_POS) begin
						state_r <= S_IDLE;
					end else begin
						state_r <= S_PAUSE;
						pause_cnt_r <= 32'h0000_0000;
					end
				end else begin
					remain_r <= (remain_r > {26'h0, prof_spd_r[15:10]} + 32'h1) ?
						remain_r - {26'h0, prof_spd_r[15:10]} - 32'h1 : 32'h0;
					if (tick_r >= (state_r == S_POS ? accel_eff * RAMP_DIV : RAMP_DIV)) begin
						tick_r <= 32'h0000_0000;
						if ({16'h0, prof_spd_r} * 32'd8 > remain_r && prof_spd_r != 0)
							prof_spd_r <= prof_spd_r - 16'sh0001;
						else if (prof_spd_r < $signed(state_r == S_POS ? dist_r : speed_r))
							prof_spd_r <= prof_spd_r + 16'sh0001;
					end
				end
				if (state_r == S_POS && remain_r != 0)
					ref_r <= dir_r ? ref_r - 32'h1 : ref_r + 32'h1;
				cmd_r[`CPM_B_BUSY] <= (state_r == S_POS);
			end
			S_PAUSE: begin
				prof_spd_r <= 16'sh0000;
				pause_cnt_r <= pause_cnt_r + 32'h0000_0001;
				if (!cmd_r[`CPM_B_PROF] || !is_comm) begin
					state_r <= S_IDLE;
				end else if (pause_cnt_r >= {16'h0000, pause_r} * TENTH_CYC) begin
					state_r <= S_RUN;
					dir_r <= ~dir_r;
					ph_r <= ~ph_r;
					remain_r <= dist_steps;
				end
			end
			default: state_r <= S_IDLE;
			endcase
			if (state_r == S_POS && remain_r == 32'h0000_0000)
				cmd_r[`CPM_B_BUSY] <= 1'b0;
			dev_r <= abs_err[15:0];
		end
	end

	// ----------------------------------------
	// Query mux, read port and speed reference
	// ----------------------------------------
	always @* begin
		case (select_r)
		16'h0000: result_r = werr_r;
		16'h0001: result_r = mpos_r[15:0];
		16'h0002: result_r = i_abs_shaft[15:0];
		default: result_r = 16'h0000;
		endcase
	end

	always @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			o_rdata <= 16'h0000;
			o_speed_ref <= 16'sh0000;
			o_ref_valid <= 1'b0;
			o_pos_ctrl <= 32'h0000_0000;
		end else begin
			o_rdata <= 16'h0000;
			if (i_rd) begin
				case (i_addr)
				`CPM_A_FACTOR: o_rdata <= factor_r;
				`CPM_A_SPEED: o_rdata <= speed_r;
				`CPM_A_DIST: o_rdata <= dist_r;
				`CPM_A_START: o_rdata <= start_r;
				`CPM_A_PAUSE: o_rdata <= pause_r;
				`CPM_A_DEV: o_rdata <= dev_r;
				`CPM_A_RESULT: o_rdata <= is_comm ? result_r : window_r;
				`CPM_A_SELECT: o_rdata <= select_r;
				`CPM_A_REF_LO: o_rdata <= ref_r[15:0];
				`CPM_A_REF_HI: o_rdata <= ref_r[31:16];
				`CPM_A_MPOS_LO: o_rdata <= mpos_r[15:0];
				`CPM_A_MPOS_HI: o_rdata <= mpos_r[31:16];
				`CPM_A_INC_LO: o_rdata <= is_comm ? vib_r[15:0] : inc_r[15:0];
				`CPM_A_INC_HI: o_rdata <= is_comm ? vib_r[31:16] : inc_r[31:16];
				`CPM_A_CMD: o_rdata <= cmd_r;
				default: o_rdata <= mode_r;
				endcase
			end
			o_ref_valid <= cmd_r[`CPM_B_REFSW] && (is_comm || is_pos);
			if (!cmd_r[`CPM_B_REFSW])
				o_speed_ref <= 16'sh0000;
			else if (state_r == S_RUN || state_r == S_POS || state_r == S_PAUSE)
				o_speed_ref <= dir_r ? -prof_spd_r : prof_spd_r;
			else if (is_comm && cmd_r[`CPM_B_JOGF] && !cmd_r[`CPM_B_PROF])
				o_speed_ref <= $signed(factor_r);
			else if (is_comm && cmd_r[`CPM_B_JOGR] && !cmd_r[`CPM_B_PROF])
				o_speed_ref <= -$signed(factor_r);
			else
				o_speed_ref <= 16'sh0000;
			o_pos_ctrl <= cmd_r[`CPM_B_FFWD] ?
				gain_term + {{16{prof_spd_r[15]}}, prof_spd_r} : gain_term;
		end
	end
endmodule
`default_nettype wire

// >>> sim/cpm_monitor.sv
// Purpose: Port checker for the motion block.
// Assumes: Mode, command and factor words are shadowed from register writes.
// Notes: The bench never rewrites the mode word while a move runs.
`include "cpm_map.vh"
`timescale 1ns/1ps
`default_nettype none
module cpm_monitor (
	// Clock and reset
	input wire i_sys_clk,
	input wire i_rst_n,
	// Register port
	input wire [3:0] i_addr,
	input wire [15:0] i_wdata,
	input wire i_wr,
	input wire i_rd,
	input wire [15:0] o_rdata,
	// Speed loop side
	input wire signed [15:0] o_speed_ref,
	input wire o_ref_valid
);
	// ----------------------------------------
	// Shadow words
	// ----------------------------------------
	logic [15:0] mode_r;
	logic [15:0] cmd_r;
	logic [15:0] fac_r;
	wire sw_w = cmd_r[`CPM_B_REFSW];
	wire comm_w = mode_r == `CPM_MODE_COMM && sw_w && !cmd_r[`CPM_B_PROF];
	wire jf_w = comm_w && cmd_r[`CPM_B_JOGF] && !cmd_r[`CPM_B_JOGR];
	wire jr_w = comm_w && cmd_r[`CPM_B_JOGR] && !cmd_r[`CPM_B_JOGF];
	wire pos_w = mode_r == `CPM_MODE_POS && o_ref_valid;
	always @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			mode_r <= `CPM_MODE_RST;
			cmd_r <= 16'h0000;
			fac_r <= `CPM_RST_MANUAL;
		end else if (i_wr) begin
			case (i_addr)
				`CPM_A_FACTOR: fac_r <= i_wdata;
				`CPM_A_CMD: cmd_r <= i_wdata;
				`CPM_A_MODE: mode_r <= i_wdata;
				default: ;
			endcase
		end
	end
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);
	sequence s_sw_off;
		!sw_w [*3];
	endsequence
	sequence s_jog_f;
		$rose(jf_w);
	endsequence
	sequence s_jog_r;
		$rose(jr_w);
	endsequence
	AST_RD_IDLE: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
		else $error("read data outside its slot");
	AST_RD_FACTOR: assert property (i_rd && i_addr == `CPM_A_FACTOR |=> o_rdata == fac_r)
		else $error("factor read back wrong");
	AST_SW_NO_VALID: assert property (s_sw_off |-> !o_ref_valid)
		else $error("reference valid with switch off");
	AST_SW_NO_SPEED: assert property (s_sw_off |-> o_speed_ref == 16'sh0000)
		else $error("speed driven with switch off");
	AST_JOG_FWD: assert property (s_jog_f |-> ##[1:1000] o_speed_ref == $signed(fac_r))
		else $error("forward jog speed not reached");
	AST_JOG_REV: assert property (s_jog_r |-> ##[1:1000] o_speed_ref == -$signed(fac_r))
		else $error("reverse jog speed not reached");
	AST_DIR_POS: assert property (pos_w && !cmd_r[`CPM_B_DIR] |-> o_speed_ref >= 0)
		else $error("negative speed on forward move");
	AST_DIR_NEG: assert property (pos_w && cmd_r[`CPM_B_DIR] |-> o_speed_ref <= 0)
		else $error("positive speed on reverse move");
endmodule
bind cpm_top cpm_monitor u_cpm_monitor (
	.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
	.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_speed_ref(o_speed_ref),
	.o_ref_valid(o_ref_valid));
`default_nettype wire

// >>> sim/cpm_motor_model.sv
// Purpose: Motor, resolver and pulse source beside the motion block.
// Assumes: One step per cycle whenever a valid speed reference is nonzero.
// Notes: Shaft angle wraps at one revolution; vibration is a constant level.
`timescale 1ns/1ps
`default_nettype none
module cpm_motor_model #(
	parameter logic [31:0] SHAFT0 = 32'h0000_0123,
	parameter logic [15:0] VIB = 16'h0003
) (
	input wire i_sys_clk,
	input wire signed [15:0] i_speed_ref,
	input wire i_ref_valid,
	output logic [31:0] o_abs_shaft,
	output logic signed [31:0] o_motor_delta,
	output logic [15:0] o_vibration,
	output logic o_pulse
);
	// ----------------------------------------
	// Shaft and pulses
	// ----------------------------------------
	initial o_abs_shaft = SHAFT0;
	initial o_pulse = 1'b0;
	assign o_vibration = VIB;
	assign o_motor_delta = !i_ref_valid ? 32'sd0 : i_speed_ref > 0 ? 32'sd1 :
		i_speed_ref < 0 ? -32'sd1 : 32'sd0;
	always @(posedge i_sys_clk) begin
		o_abs_shaft <= (o_abs_shaft + o_motor_delta) & 32'h0000_0fff;
	end
	// The direction line does not exist here, so it is always low.
	task automatic send(input int n);
		repeat (n) begin
			@(posedge i_sys_clk);
			o_pulse <= 1'b1;
			repeat (2) @(posedge i_sys_clk);
			o_pulse <= 1'b0;
			@(posedge i_sys_clk);
		end
	endtask
endmodule
`default_nettype wire

// >>> sim/test_cpm_top.sv
// Purpose: Self-checking bench of the motion block.
// Assumes: Shortened ramp and wiring-test counts.
// Notes: Positioner moves are short, so the bench waits stay small.
`include "cpm_map.vh"
`timescale 1ns/1ps
`default_nettype none
module test_cpm_top;
	logic i_sys_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic [3:0] i_addr = 4'h0;
	logic [15:0] i_wdata = 16'h0000;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [2:0] i_wire_fault = 3'h0;
	logic i_hw_enable = 1'b0;
	logic i_sw_enable = 1'b0;
	logic [15:0] i_disable_delay = 16'h0000;
	logic [15:0] o_rdata, i_vibration, rv;
	logic signed [15:0] o_speed_ref;
	logic signed [31:0] o_pos_ctrl, i_motor_delta;
	logic [31:0] i_abs_shaft;
	logic o_ref_valid, i_pulse;
	int n_mismatch = 0;
	int comparisons = 0;
	cpm_top #(.RAMP_DIV(4), .WIRE_CYCLES(10)) u_cpm_top (.i_sys_clk, .i_rst_n, .i_addr,
		.i_wdata, .i_wr, .i_rd, .o_rdata, .i_abs_shaft, .i_motor_delta, .i_vibration,
		.i_pulse, .i_wire_fault, .i_hw_enable, .i_sw_enable, .i_disable_delay,
		.o_speed_ref, .o_ref_valid, .o_pos_ctrl);
	cpm_motor_model u_cpm_motor_model (.i_sys_clk, .i_speed_ref(o_speed_ref),
		.i_ref_valid(o_ref_valid), .o_abs_shaft(i_abs_shaft),
		.o_motor_delta(i_motor_delta), .o_vibration(i_vibration), .o_pulse(i_pulse));
	initial forever #2 i_sys_clk = ~i_sys_clk;
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic stop_test();
		$display("counts: %0d mismatches, %0d comparisons", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge i_sys_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_sys_clk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge i_sys_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_sys_clk);
		i_rd <= 1'b0;
		#1 rv = o_rdata;
	endtask
	task automatic exp_rd(input logic [3:0] a, input logic [15:0] v);
		rd(a);
		chk(rv, v);
	endtask
	// Polling reads keep the port busy, with one idle cycle between successive reads.
	task automatic wait_rd(input logic [3:0] a, input logic [15:0] m, input logic [15:0] v);
		int k;
		for (k = 0; k < 5000; k++) begin
			rd(a);
			if ((rv & m) === v) break;
		end
		chk(rv & m, v);
		if (k == 5000) stop_test();
	endtask
	task automatic wait_spd(input logic signed [15:0] v);
		int k;
		#1;
		for (k = 0; k < 1000 && o_speed_ref !== v; k++) #4;
		chk(o_speed_ref, v);
		if (k == 1000) stop_test();
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_defaults();
		exp_rd(`CPM_A_FACTOR, `CPM_RST_MANUAL);
		exp_rd(`CPM_A_SPEED, `CPM_RST_PSPEED);
		exp_rd(`CPM_A_START, `CPM_RST_START);
		exp_rd(`CPM_A_PAUSE, `CPM_RST_PAUSE);
		exp_rd(`CPM_A_MODE, `CPM_MODE_RST);
		$display("defaults done");
	endtask
	task automatic t_jog();
		wr(`CPM_A_MODE, `CPM_MODE_COMM);
		wr(`CPM_A_CMD, 16'h0002);
		wr(`CPM_A_CMD, 16'h2002);
		wait_spd(16'sd100);
		chk(o_ref_valid, 1'b1);
		wr(`CPM_A_CMD, 16'h2004);
		wait_spd(-16'sd100);
		wr(`CPM_A_CMD, 16'h0000);
		wait_spd(16'sd0);
		$display("jog done");
	endtask
	task automatic t_wire();
		i_hw_enable <= 1'b1;
		wr(`CPM_A_SELECT, 16'h0000);
		exp_rd(`CPM_A_RESULT, `CPM_ERR_NOTRUN);
		for (int k = 0; k < 6; k++) begin
			i_wire_fault <= (k < 5) ? k[2:0] : 3'h0;
			i_disable_delay <= (k == 5) ? 16'h0001 : 16'h0000;
			wr(`CPM_A_CMD, 16'h0008);
			wait_rd(`CPM_A_CMD, 16'h0008, 16'h0000);
			exp_rd(`CPM_A_RESULT, k[15:0]);
		end
		wr(`CPM_A_CMD, 16'h0008);
		wr(`CPM_A_MODE, `CPM_MODE_RST);
		wr(`CPM_A_MODE, `CPM_MODE_COMM);
		exp_rd(`CPM_A_RESULT, `CPM_ERR_ABORT);
		$display("wiring done");
	endtask
	task automatic t_vib();
		wr(`CPM_A_INC_LO, 16'h0000);
		wr(`CPM_A_CMD, 16'h0010);
		rd(`CPM_A_INC_LO);
		chk(rv !== 16'h0000, 1'b1);
		wr(`CPM_A_CMD, 16'h0000);
		wr(`CPM_A_INC_LO, 16'h0000);
		exp_rd(`CPM_A_INC_LO, 16'h0000);
		$display("vibration done");
	endtask
	task automatic t_prof();
		wr(`CPM_A_START, `CPM_SP_FULL_NEG);
		wr(`CPM_A_DIST, 16'h0001);
		wr(`CPM_A_CMD, 16'h2001);
		repeat (40) @(posedge i_sys_clk);
		#1 chk(o_speed_ref < 0, 1'b1);
		wr(`CPM_A_CMD, 16'h0000);
		wait_spd(16'sd0);
		$display("test profile done");
	endtask
	task automatic t_pos();
		wr(`CPM_A_MODE, `CPM_MODE_POS);
		wr(`CPM_A_INC_LO, 16'h0040);
		wr(`CPM_A_INC_HI, 16'h0000);
		wr(`CPM_A_CMD, 16'h2100);
		wait_rd(`CPM_A_CMD, 16'h0080, 16'h0080);
		wr(`CPM_A_SPEED, 16'h0005);
		exp_rd(`CPM_A_SPEED, `CPM_RST_PSPEED);
		wait_rd(`CPM_A_CMD, 16'h0080, 16'h0000);
		wr(`CPM_A_CMD, 16'h2010);
		wr(`CPM_A_CMD, 16'h2110);
		wait_rd(`CPM_A_CMD, 16'h0080, 16'h0080);
		wait_rd(`CPM_A_CMD, 16'h0080, 16'h0000);
		$display("positioner done");
	endtask
	task automatic t_resets();
		wr(`CPM_A_CMD, 16'h0000);
		wr(`CPM_A_CMD, 16'h0800);
		exp_rd(`CPM_A_MPOS_LO, i_abs_shaft[15:0]);
		exp_rd(`CPM_A_REF_LO, i_abs_shaft[15:0]);
		wr(`CPM_A_CMD, 16'h0400);
		exp_rd(`CPM_A_MPOS_LO, 16'h0000);
		exp_rd(`CPM_A_REF_LO, 16'h0000);
		$display("resets done");
	endtask
	task automatic t_servo();
		wr(`CPM_A_RESULT, 16'h0002);
		wr(`CPM_A_SELECT, 16'h0004);
		wr(`CPM_A_REF_LO, 16'h0010);
		wait_rd(`CPM_A_CMD, 16'h0020, 16'h0020);
		chk(o_pos_ctrl, 32'h0000_0040);
		wr(`CPM_A_CMD, 16'h0000);
		exp_rd(`CPM_A_CMD, 16'h0020);
		wr(`CPM_A_CMD, 16'h1000);
		wr(`CPM_A_CMD, 16'h0000);
		exp_rd(`CPM_A_CMD, 16'h0000);
		chk(o_pos_ctrl, 32'h0000_0000);
		$display("servo error done");
	endtask
	task automatic t_pulse();
		wr(`CPM_A_FACTOR, 16'h0003);
		wr(`CPM_A_CMD, 16'h0204);
		wr(`CPM_A_CMD, 16'h0200);
		u_cpm_motor_model.send(5);
		exp_rd(`CPM_A_INC_LO, 16'h000f);
		exp_rd(`CPM_A_INC_HI, 16'h0000);
		wr(`CPM_A_CMD, 16'h0204);
		exp_rd(`CPM_A_INC_LO, 16'h0000);
		$display("pulse input done");
	endtask
	initial begin
		repeat (10) @(posedge i_sys_clk);
		i_rst_n <= 1'b1;
		t_defaults();
		t_jog();
		t_wire();
		t_vib();
		t_prof();
		t_pos();
		t_resets();
		t_servo();
		t_pulse();
		stop_test();
	end
endmodule
`default_nettype wire
